// File: core/psf_ctrl.sv
module psf_ctrl
  import psf_pkg::*;
#(
  parameter bit AUTO_RESTART = 1'b1,
  parameter int OVP_DEB_CYC = OVP_DEBOUNCE_CYC,
  parameter int CLAMP_CYC = SHORT_CLAMP_CYC,
  parameter int THERM_REC_CYC = THERMAL_RESTART_CYC,
  parameter int RETRY_AUTO_CYC = SHORT_RETRY_AUTO_CYC,
  parameter int RETRY_LATCH_CYC = SHORT_RETRY_LATCH_CYC,
  parameter int EN_DELAY_CYC = ENABLE_DELAY_CYC,
  parameter longint DISC_CYC = DISCHARGE_TIMEOUT_CYC
) (
  // Clock and power-on reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Control from the system power controller
  input wire logic ENABLE_IN,
  // Analog comparator results
  input wire psf_sense_s SENSE_IN,
  // Switch control
  output logic SWITCH_ON_OUT,
  output logic RAMP_ACTIVE_OUT,
  output logic DISCHARGE_OUT,
  // Open-drain fault flag, driven low while a fault is flagged
  output logic FAULT_FLAG_N_OUT,
  output logic FAULT_FLAG_N_OE_OUT
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int NS = $bits(psf_sense_s) + 1;
  logic [NS-1:0] meta_q;
  logic [NS-1:0] sync_q;
  psf_sense_s s;
  logic en;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {ENABLE_IN, SENSE_IN};
      sync_q <= meta_q;
    end
  end

  // Enable is assumed clean logic levels, so no extra filtering.
  assign en = sync_q[NS-1];
  assign s = psf_sense_s'(sync_q[NS-2:0]);

  // ---------------------------------------------------------------
  // Enable qualification
  // ---------------------------------------------------------------
  logic enabled;
  logic en_prev_q;
  logic en_fall;

  assign enabled = en && s.above_lockout;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= enabled;
    end
  end

  assign en_fall = en_prev_q && !en;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  psf_state_e state_q;
  logic [31:0] timer_q;
  logic [31:0] ovp_cnt_q;
  logic [31:0] clamp_cnt_q;
  logic [2:0] retry_q;
  logic fault_q;
  logic ovp_trip;
  logic short_trip;
  logic any_fault;

  // Overvoltage must persist for the debounce while conducting.
  assign ovp_trip = s.overvoltage_guard && (ovp_cnt_q >= 32'(OVP_DEB_CYC - 1));
  // Only an unbroken clamp interval during the ramp counts.
  assign short_trip = s.current_clamp && (clamp_cnt_q >= 32'(CLAMP_CYC - 1));
  assign any_fault = s.overvoltage_guard || s.thermal_shutdown;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ovp_cnt_q <= '0;
    end else if (state_q == PSF_RAMP || state_q == PSF_ON) begin
      ovp_cnt_q <= s.overvoltage_guard ? ovp_cnt_q + 32'h1 : 32'h0;
    end else begin
      ovp_cnt_q <= '0;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      clamp_cnt_q <= '0;
    end else if (state_q == PSF_RAMP && s.current_clamp && !s.ramp_done) begin
      clamp_cnt_q <= clamp_cnt_q + 32'h1;
    end else begin
      clamp_cnt_q <= '0;
    end
  end

  // The whole fault history is cleared by power-on reset.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_q <= PSF_OFF;
      timer_q <= '0;
      retry_q <= RETRY_RESET;
      fault_q <= 1'b0;
    end else if (!enabled) begin
      // Dropping enable leaves any latch; the next rise starts fresh.
      state_q <= PSF_OFF;
      timer_q <= '0;
      retry_q <= RETRY_RESET;
      fault_q <= 1'b0;
    end else begin
      unique case (state_q)
        PSF_OFF: begin
          state_q <= PSF_CHECK;
        end
        PSF_CHECK: begin
          if (s.overvoltage_guard) begin
            // Overvoltage blocks turn-on and latches in both variants.
            fault_q <= 1'b1;
            state_q <= PSF_LATCHED;
          end else if (s.thermal_shutdown) begin
            fault_q <= 1'b1;
            timer_q <= '0;
            state_q <= AUTO_RESTART ? PSF_WAIT : PSF_LATCHED;
          end else begin
            timer_q <= '0;
            state_q <= PSF_DELAY;
          end
        end
        PSF_DELAY: begin
          if (any_fault) begin
            state_q <= PSF_CHECK;
          end else if (timer_q >= 32'(EN_DELAY_CYC - 1)) begin
            state_q <= PSF_RAMP;
          end else begin
            timer_q <= timer_q + 32'h1;
          end
        end
        PSF_RAMP, PSF_ON: begin
          timer_q <= '0;
          if (ovp_trip) begin
            fault_q <= 1'b1;
            state_q <= PSF_LATCHED;
          end else if (s.thermal_shutdown) begin
            fault_q <= 1'b1;
            state_q <= AUTO_RESTART ? PSF_WAIT : PSF_LATCHED;
          end else if (short_trip) begin
            fault_q <= 1'b1;
            if (!AUTO_RESTART && retry_q >= SHORT_RETRY_LIMIT) begin
              state_q <= PSF_LATCHED;
            end else begin
              retry_q <= retry_q + 3'h1;
              state_q <= PSF_WAIT;
            end
          end else if (state_q == PSF_RAMP && s.ramp_done) begin
            state_q <= PSF_ON;
          end
        end
        PSF_WAIT: begin
          // Thermal waits for the hysteresis to clear before the blanking runs.
          if (s.thermal_shutdown) begin
            timer_q <= '0;
          end else if (timer_q >= 32'(retry_q != RETRY_RESET ?
              (AUTO_RESTART ? RETRY_AUTO_CYC : RETRY_LATCH_CYC) - 1 :
              THERM_REC_CYC - 1)) begin
            timer_q <= '0;
            fault_q <= 1'b0;
            state_q <= PSF_RAMP; // new soft-start
          end else begin
            timer_q <= timer_q + 32'h1;
          end
        end
        PSF_LATCHED: begin
          state_q <= PSF_LATCHED;
        end
        default: begin
          state_q <= PSF_OFF;
        end
      endcase
    end
  end

  // Reverse block drops the gate without touching the flag or state.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      SWITCH_ON_OUT <= 1'b0;
      RAMP_ACTIVE_OUT <= 1'b0;
      FAULT_FLAG_N_OUT <= 1'b0;
      FAULT_FLAG_N_OE_OUT <= 1'b0;
    end else begin
      SWITCH_ON_OUT <= enabled && (state_q == PSF_RAMP || state_q == PSF_ON) &&
        !s.reverse_block && !s.thermal_shutdown && !ovp_trip;
      RAMP_ACTIVE_OUT <= enabled && state_q == PSF_RAMP;
      FAULT_FLAG_N_OUT <= 1'b0;
      FAULT_FLAG_N_OE_OUT <= fault_q;
    end
  end

  // ---------------------------------------------------------------
  // Input discharge with watchdog
  // ---------------------------------------------------------------
  logic [63:0] disc_cnt_q;
  logic disc_expired_q;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      disc_cnt_q <= '0;
      disc_expired_q <= 1'b0;
    end else if (en) begin
      disc_cnt_q <= '0;
      disc_expired_q <= 1'b0;
    end else if (en_fall) begin
      disc_cnt_q <= '0; // timeout measured from enable fall
      disc_expired_q <= 1'b0;
    end else if (disc_cnt_q >= 64'(DISC_CYC - 1)) begin
      disc_expired_q <= 1'b1;
    end else begin
      disc_cnt_q <= disc_cnt_q + 64'h1;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      DISCHARGE_OUT <= 1'b0;
    end else begin
      DISCHARGE_OUT <= !en && s.below_discharge_detect && !disc_expired_q &&
        !s.below_discharge_floor && !(s.output_below_lockout && !s.above_lockout);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence clamp_start_s;
    state_q == PSF_RAMP && s.current_clamp && clamp_cnt_q == 32'h0;
  endsequence

  ovp_flag_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (state_q == PSF_CHECK && enabled && s.overvoltage_guard) |=> ##1 FAULT_FLAG_N_OE_OUT)
    else $error("overvoltage did not raise fault flag");
  latch_hold_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (state_q == PSF_LATCHED && enabled) |=> state_q == PSF_LATCHED)
    else $error("latched state left while enabled");
  disabled_off_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !$past(enabled) |-> !SWITCH_ON_OUT)
    else $error("switch on while not enabled");
  reverse_off_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $past(s.reverse_block) |-> !SWITCH_ON_OUT)
    else $error("switch on during reverse block");
  clamp_clear_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !s.current_clamp |=> clamp_cnt_q == 32'h0)
    else $error("clamp timer not cleared");
  ramp_only_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q != PSF_RAMP |=> clamp_cnt_q == 32'h0)
    else $error("clamp timer runs outside ramp");
  clamp_grow_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    clamp_start_s ##1 (state_q == PSF_RAMP && s.current_clamp) |-> clamp_cnt_q == 32'h1)
    else $error("clamp timer not counting");
  retry_cap_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !AUTO_RESTART |-> retry_q <= SHORT_RETRY_LIMIT)
    else $error("retry count exceeded limit");
  disc_en_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $past(en) |-> !DISCHARGE_OUT)
    else $error("discharge while enabled");
  therm_latch_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (!AUTO_RESTART && state_q == PSF_ON && s.thermal_shutdown && enabled && !ovp_trip)
    |=> state_q == PSF_LATCHED)
    else $error("thermal fault did not latch");

endmodule

// File: core/psf_pkg.sv
package psf_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int OVP_DEBOUNCE_US = 512;
  localparam int SHORT_CLAMP_US = 512;
  localparam int THERMAL_RESTART_MS = 64;
  localparam int SHORT_RETRY_AUTO_MS = 64;
  localparam int SHORT_RETRY_LATCH_MS = 2;
  localparam int ENABLE_DELAY_MS = 10;
  localparam int DISCHARGE_TIMEOUT_S = 1;
  localparam int OVP_DEBOUNCE_CYC = OVP_DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
  localparam int SHORT_CLAMP_CYC = SHORT_CLAMP_US * 1000 / CLK_PERIOD_NS;
  localparam int THERMAL_RESTART_CYC = THERMAL_RESTART_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SHORT_RETRY_AUTO_CYC = SHORT_RETRY_AUTO_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SHORT_RETRY_LATCH_CYC = SHORT_RETRY_LATCH_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ENABLE_DELAY_CYC = ENABLE_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam longint DISCHARGE_TIMEOUT_CYC = 64'(DISCHARGE_TIMEOUT_S) * 1000000000 / CLK_PERIOD_NS;
  localparam logic [2:0] SHORT_RETRY_LIMIT = 3'h4;
  localparam logic [2:0] RETRY_RESET = 3'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PSF_OFF, PSF_CHECK, PSF_DELAY, PSF_RAMP, PSF_ON, PSF_WAIT, PSF_LATCHED
  } psf_state_e;

  typedef struct packed {
    logic overvoltage_guard;
    logic thermal_shutdown;
    logic reverse_block;
    logic current_clamp;
    logic ramp_done;
    logic above_lockout;
    logic below_discharge_detect;
    logic below_discharge_floor;
    logic output_below_lockout;
  } psf_sense_s;
endpackage

// File: sim/protection_switch_fault_controller_tb.sv
module protection_switch_fault_controller_tb
  import psf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en_req = 1'b0;
  psf_sense_s sense = '0;
  logic en, sw, ramp, disc, fl_n, fl_oe, fault;
  logic sw_l, fl_n_l, fl_oe_l, fault_l;
  int m;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] lfsr = 32'h2ed7;
  int n;
  always #5 clk = ~clk;
  psf_ctrl #(.AUTO_RESTART(1'b1), .OVP_DEB_CYC(N), .CLAMP_CYC(N), .THERM_REC_CYC(N),
    .RETRY_AUTO_CYC(N), .RETRY_LATCH_CYC(N), .EN_DELAY_CYC(N), .DISC_CYC(N)) u_psf_ctrl (
    .CLK_IN(clk), .RESET_IN(rst), .ENABLE_IN(en), .SENSE_IN(sense), .SWITCH_ON_OUT(sw),
    .RAMP_ACTIVE_OUT(ramp), .DISCHARGE_OUT(disc), .FAULT_FLAG_N_OUT(fl_n),
    .FAULT_FLAG_N_OE_OUT(fl_oe));
  psf_host u_psf_host (.clk_in(clk), .en_req_in(en_req), .flag_n_in(fl_n),
    .flag_oe_in(fl_oe), .enable_out(en), .fault_out(fault));
  // The latch-off variant sees the same pins so both recoveries can be compared.
  psf_ctrl #(.AUTO_RESTART(1'b0), .OVP_DEB_CYC(N), .CLAMP_CYC(N), .THERM_REC_CYC(N),
    .RETRY_AUTO_CYC(N), .RETRY_LATCH_CYC(N), .EN_DELAY_CYC(N), .DISC_CYC(N)) u_psf_ctrl_latch (
    .CLK_IN(clk), .RESET_IN(rst), .ENABLE_IN(en), .SENSE_IN(sense), .SWITCH_ON_OUT(sw_l),
    .RAMP_ACTIVE_OUT(), .DISCHARGE_OUT(), .FAULT_FLAG_N_OUT(fl_n_l),
    .FAULT_FLAG_N_OE_OUT(fl_oe_l));
  psf_host u_psf_host_latch (.clk_in(clk), .en_req_in(en_req), .flag_n_in(fl_n_l),
    .flag_oe_in(fl_oe_l), .enable_out(), .fault_out(fault_l));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // The counters can be two cycles coarse, so a minimum gap allows that slack.
  function automatic logic at_least(input int seen, input int lim);
    return seen >= lim - 2;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_sw(input logic lvl, input int lim, output int k);
    k = 0;
    while (sw !== lvl && k < lim) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic count_rises(input int k, output int ra, output int rl);
    logic pa, pl;
    ra = 0;
    rl = 0;
    pa = sw;
    pl = sw_l;
    repeat (k) begin
      cyc(1);
      if (sw === 1'b1 && pa !== 1'b1) ra++;
      if (sw_l === 1'b1 && pl !== 1'b1) rl++;
      pa = sw;
      pl = sw_l;
    end
  endtask
  task automatic start();
    en_req = 1'b0;
    sense = '0;
    sense.above_lockout = 1'b1;
    cyc(6);
  endtask
  task automatic turn_on(input logic done_ramp);
    en_req = 1'b1;
    wait_sw(1'b1, 4 * N, n);
    sense.ramp_done = done_ramp;
    cyc(4);
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The whole sequence needs under three thousand cycles.
  initial begin
    cyc(20000);
    mismatches++;
    $display("watchdog expired");
    complete_run();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    cyc(8);
    rst = 1'b0;
    chk("switch after reset", sw, 1'b0);
    chk("fault after reset", fault, 1'b0);
    start();
    sense.above_lockout = 1'b0;
    en_req = 1'b1;
    cyc(4 * N);
    chk("switch in lockout", sw, 1'b0);
    $display("test lockout done");
    start();
    en_req = 1'b1;
    wait_sw(1'b1, 4 * N, n);
    chk("enable delay", at_least(n, N), 1'b1);
    chk("enable delay max", n <= N + 8, 1'b1);
    for (int i = 0; i < 5; i++) begin
      lfsr = next_rand(lfsr);
      sense.current_clamp = 1'b1;
      cyc(int'(lfsr[3:0]) + 1);
      sense.current_clamp = 1'b0;
      cyc(3);
    end
    chk("ramp under short clamps", ramp, 1'b1);
    sense.current_clamp = 1'b1;
    wait_sw(1'b0, 2 * N, n);
    chk("clamp time", at_least(n, N), 1'b1);
    chk("short fault", fault, 1'b1);
    sense.current_clamp = 1'b0;
    wait_sw(1'b1, 4 * N, n);
    chk("retry gap", at_least(n, N), 1'b1);
    sense.ramp_done = 1'b1;
    cyc(4);
    chk("ramp finished", ramp, 1'b0);
    sense.current_clamp = 1'b1;
    cyc(3 * N);
    chk("clamp after ramp", sw, 1'b1);
    sense.current_clamp = 1'b0;
    sense.reverse_block = 1'b1;
    cyc(5);
    chk("reverse off", sw, 1'b0);
    chk("reverse no fault", fault, 1'b0);
    $display("test short and reverse done");
    start();
    turn_on(1'b1);
    sense.thermal_shutdown = 1'b1;
    cyc(5);
    chk("thermal off", sw, 1'b0);
    chk("thermal fault", fault, 1'b1);
    sense.thermal_shutdown = 1'b0;
    wait_sw(1'b1, 4 * N, n);
    chk("thermal blanking", at_least(n, N), 1'b1);
    chk("thermal restart", sw, 1'b1);
    chk("thermal latched", sw_l, 1'b0);
    chk("thermal latched flag", fault_l, 1'b1);
    $display("test thermal done");
    start();
    sense.current_clamp = 1'b1;
    en_req = 1'b1;
    count_rises(8 * (2 * N + 4), n, m);
    chk("latch attempts", m, 32'(SHORT_RETRY_LIMIT) + 1);
    chk("auto keeps retrying", n > 32'(SHORT_RETRY_LIMIT) + 1, 1'b1);
    chk("short latched flag", fault_l, 1'b1);
    sense.current_clamp = 1'b0;
    cyc(4 * N);
    chk("short latch holds", sw_l, 1'b0);
    chk("auto back on", sw, 1'b1);
    $display("test latch-off retries done");
    start();
    turn_on(1'b1);
    for (int i = 0; i < 4; i++) begin
      sense.overvoltage_guard = 1'b1;
      cyc(N / 2);
      sense.overvoltage_guard = 1'b0;
      cyc(3);
    end
    chk("brief overvoltage", sw, 1'b1);
    sense.overvoltage_guard = 1'b1;
    cyc(N - 3);
    chk("overvoltage debounce", sw, 1'b1);
    cyc(8);
    chk("overvoltage off", sw, 1'b0);
    chk("overvoltage fault", fault, 1'b1);
    sense.overvoltage_guard = 1'b0;
    cyc(4 * N);
    chk("stays off", sw, 1'b0);
    en_req = 1'b0;
    cyc(6);
    chk("fault after toggle", fault, 1'b0);
    turn_on(1'b1);
    chk("on after toggle", sw, 1'b1);
    $display("test overvoltage running done");
    start();
    sense.overvoltage_guard = 1'b1;
    en_req = 1'b1;
    cyc(10);
    chk("fault at check", fault, 1'b1);
    cyc(3 * N);
    chk("turn-on blocked", sw, 1'b0);
    $display("test overvoltage at enable done");
    for (int k = 0; k < 3; k++) begin
      start();
      en_req = 1'b1;
      cyc(5);
      en_req = 1'b0;
      sense.below_discharge_detect = 1'b1;
      sense.output_below_lockout = (k == 2);
      sense.above_lockout = (k != 2);
      cyc(6);
      chk("discharge on", disc, k != 2);
      sense.below_discharge_floor = (k == 0);
      cyc(k == 1 ? 3 * N : 5);
      chk("discharge stop", disc, 1'b0);
    end
    $display("test discharge done");
    complete_run();
  end
endmodule

// File: sim/psf_host.sv
module psf_host
  import psf_pkg::*;
(
  // Clock and request
  input wire logic clk_in,
  input wire logic en_req_in,
  // Fault pin pieces
  input wire logic flag_n_in,
  input wire logic flag_oe_in,
  // Pin levels
  output logic enable_out,
  output logic fault_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Enable is a full level that moves only after a rising edge.
  always @(posedge clk_in) enable_out <= (en_req_in === 1'b1);
  // The pin has a pull-up, so it reads low only while the device sinks it.
  assign fault_out = (flag_oe_in === 1'b1) ? ~flag_n_in : 1'b0;
endmodule
